// ===== src/ssl_loader.sv
// sensor start-up loader: apb control, version detect, table load, tuning, readback check
// Function
// - load whole table before capture enabled
// - pick table from detected silicon version
// - read version code register first
// - version 2 lane and current fields
// - version 2 transfer, reset, precharge, reference levels
// - version 2 both configuration enables set
// - version 3 exposure mode, calibration off
// - version 3 four bias currents
// - version 3 transfer, reset, precharge, reference levels
// - version 3 preamp, spare byte, clamp
// - gain, ramps, offset tunable per sensor
// - version 2 gain and ramp ranges
// - version 3 ramp start, ranges
// - fourteen-bit dark offset split in two
// - both ramp registers always equal
// - dark offset calibration by software
// - gain raised by software for full scale
// - retune offset after every gain change
// - gain trim for mean grey
`timescale 1ns/1ps
`default_nettype none
module ssl_loader #(
	parameter logic [7:0] VER_A_CODE = 8'hA2, // arbitrary code for the older silicon
	parameter logic [7:0] VER_B_CODE = 8'hB3  // arbitrary code for the newer silicon
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sensor register port
	output ssl_pkg::ssl_sreq_type sreq,
	input wire ssl_pkg::ssl_sack_type sack,
	// capture permission
	output logic capture_enable
);
	import ssl_pkg::*;

	// flow of one pass, as software sees it:
	// - a load order first reads the version code, then picks the table
	// - an unknown code stops at once with the error flag and no writes
	// - each entry is read, merged under its mask, then written back
	// - a tune order skips the version read and the fixed table
	// - the tuning part always follows: both ramps, gain, offset low, offset high
	// - after the write pass a second pass reads every entry again
	// - only the masked field bits are compared in that second pass
	// - done rises only when the whole second pass matched
	// hazards and limits:
	// - software registers hold raw values; limits apply only on the way out,
	//   so a read of gain, or of ramp unless a newer-silicon load reset it, shows what software wrote, not what was sent
	// - writes while busy are dropped silently; poll busy before writing
	// - the sensor port answers in its own time; there is no timeout here,
	//   a dead serial engine leaves the block busy until reset
	// - dark offset, gain and mean-grey trimming need image data that this
	//   block never sees, so software runs those loops and uses tune orders
	// - the flip setting is never touched, so readout order stays as the sensor had it

	// equal codes would make the version decode ambiguous
	if (VER_A_CODE == VER_B_CODE) begin : g_code_check
		$error("version codes must differ");
	end

	// whole state of the block
	typedef struct packed {
		ssl_state_type st;
		logic [4:0] idx;     // table position
		logic verify;        // readback pass
		logic tune_only;     // skip the fixed table
		logic ver_b;         // newer silicon detected
		logic [7:0] ver;     // raw version code
		logic ver_ok;        // version was recognised
		logic done;          // load and check complete
		logic err;           // mismatch or unknown version
		logic [7:0] rd;      // byte read for merge
		logic [7:0] ramp;    // ramp start, shared
		logic [7:0] gain;    // converter gain
		logic [13:0] offset; // dark offset
		ssl_sreq_type sreq;
		logic [31:0] prdata;
		logic pslverr;
	} ssl_all_type;

	ssl_all_type s_q; // registered state
	ssl_all_type s_d; // next state

	// fixed-table entry by version and index
	function automatic ssl_entry_type fixed_entry(input logic vb, input logic [4:0] i);
		ssl_entry_type e;
		e = '{addr: SSL_A_VERSION_CODE, mask: 8'h00, val: 8'h00};
		if (!vb) begin
			case (i)
				5'h00: e = '{SSL_A_OUTPUT_LANE_ENABLE, SSL_M3, 8'h07};
				5'h01: e = '{SSL_A_COLUMN_BIAS_CURRENT, SSL_M4, 8'h04};
				5'h02: e = '{SSL_A_COLUMN_PRECHARGE_CURRENT, SSL_M4, 8'h01};
				5'h03: e = '{SSL_A_TRANSFER_LOW_LEVEL, SSL_M7, 8'h40};
				5'h04: e = '{SSL_A_RESET_LOW_LEVEL, SSL_M7, 8'h40};
				5'h05: e = '{SSL_A_PRECHARGE_LEVEL, SSL_M7, 8'h65};
				5'h06: e = '{SSL_A_REFERENCE_LEVEL, SSL_M7, 8'h6A};
				5'h07: e = '{SSL_A_CONFIG_ENABLE_SECOND, SSL_M1, 8'h01};
				5'h08: e = '{SSL_A_CONFIG_ENABLE_FIRST, SSL_M1, 8'h01};
				default: e = '{SSL_A_VERSION_CODE, 8'h00, 8'h00};
			endcase
		end else begin
			case (i)
				5'h00: e = '{SSL_A_EXPOSURE_MODE_SELECT, SSL_M3, 8'h04};
				5'h01: e = '{SSL_A_CALIBRATION_ENABLES, SSL_M2, 8'h00};
				5'h02: e = '{SSL_A_COLUMN_BIAS_CURRENT, SSL_M4, 8'h04};
				5'h03: e = '{SSL_A_COLUMN_PRECHARGE_CURRENT, SSL_M4, 8'h01};
				5'h04: e = '{SSL_A_CONVERTER_BIAS_CURRENT, SSL_M4, 8'h0E};
				5'h05: e = '{SSL_A_AMPLIFIER_BIAS_CURRENT, SSL_M4, 8'h0C};
				5'h06: e = '{SSL_A_TRANSFER_LOW_LEVEL, SSL_M7, 8'h40};
				5'h07: e = '{SSL_A_RESET_LOW_LEVEL, SSL_M7, 8'h40};
				5'h08: e = '{SSL_A_PRECHARGE_LEVEL, SSL_M7, 8'h65};
				5'h09: e = '{SSL_A_REFERENCE_LEVEL, SSL_M7, 8'h6A};
				5'h0A: e = '{SSL_A_PREAMP_GAIN_SELECT, SSL_M2, 8'h01};
				5'h0B: e = '{SSL_A_SPARE_TUNING_BYTE, SSL_M8, 8'h01};
				5'h0C: e = '{SSL_A_BLACK_SUN_CLAMP, SSL_M6, 8'h62};
				default: e = '{SSL_A_VERSION_CODE, 8'h00, 8'h00};
			endcase
		end
		return e;
	endfunction : fixed_entry

	// tuning entry; both ramps take the one shared value
	function automatic ssl_entry_type tune_entry(input logic [4:0] i, input logic [7:0] r,
			input logic [7:0] g, input logic [13:0] o);
		ssl_entry_type e;
		e = '{addr: SSL_A_VERSION_CODE, mask: 8'h00, val: 8'h00};
		case (i)
			5'h00: e = '{SSL_A_RAMP_START_FIRST, SSL_M7, r};
			5'h01: e = '{SSL_A_RAMP_START_SECOND, SSL_M7, r};
			5'h02: e = '{SSL_A_CONVERTER_GAIN, SSL_M8, g};
			5'h03: e = '{SSL_A_DARK_OFFSET_LOW, SSL_M8, o[7:0]};
			5'h04: e = '{SSL_A_DARK_OFFSET_HIGH, SSL_M6, {2'b00, o[13:8]}};
			default: e = '{SSL_A_VERSION_CODE, 8'h00, 8'h00};
		endcase
		return e;
	endfunction : tune_entry

	// clamp a value into an inclusive range
	function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp8

	logic [4:0] fix_len;      // length of the chosen fixed table
	logic [4:0] tune_idx;     // index into the tuning part
	logic in_fixed;           // current index is in the fixed part
	ssl_entry_type cur;       // current entry
	logic [7:0] gain_lim;     // gain after range limiting
	logic [7:0] ramp_lim;     // ramp after range limiting
	logic setup;              // apb setup cycle
	logic [31:0] rd_word;     // apb read mux

	assign fix_len = s_q.ver_b ? SSL_V3_LEN : SSL_V2_LEN;
	assign in_fixed = !s_q.tune_only && (s_q.idx < fix_len);
	assign tune_idx = s_q.tune_only ? s_q.idx : 5'(s_q.idx - fix_len);
	assign ramp_lim = clamp8(s_q.ramp, SSL_RAMP_MIN, SSL_RAMP_MAX);
	assign gain_lim = s_q.ver_b ? clamp8(s_q.gain, 8'h00, SSL_GAIN_V3_MAX) :
		clamp8(s_q.gain, SSL_GAIN_V2_MIN, SSL_GAIN_V2_MAX);
	assign cur = in_fixed ? fixed_entry(s_q.ver_b, s_q.idx) : tune_entry(tune_idx, ramp_lim, gain_lim, s_q.offset);
	assign setup = psel && !penable;

	// apb read data, computed in setup so the access phase needs no wait
	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr)
			SSL_OFS_CTRL: rd_word = 32'h0000_0000;
			SSL_OFS_STATUS: begin
				rd_word[SSL_ST_BUSY_BIT] = (s_q.st != SSL_IDLE);
				rd_word[SSL_ST_DONE_BIT] = s_q.done;
				rd_word[SSL_ST_ERR_BIT] = s_q.err;
				rd_word[SSL_ST_VERB_BIT] = s_q.ver_b;
				rd_word[SSL_ST_VERS_LSB +: 8] = s_q.ver;
			end
			SSL_OFS_RAMP: rd_word[7:0] = s_q.ramp;
			SSL_OFS_GAIN: rd_word[7:0] = s_q.gain;
			SSL_OFS_OFFSET: rd_word[13:0] = s_q.offset;
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// next-state logic for the whole block
	always_comb begin
		s_d = s_q;
		// apb: latch answer in setup, act on writes in access
		if (setup) begin
			s_d.prdata = rd_word;
			s_d.pslverr = !(paddr == SSL_OFS_CTRL || paddr == SSL_OFS_STATUS || paddr == SSL_OFS_RAMP ||
				paddr == SSL_OFS_GAIN || paddr == SSL_OFS_OFFSET);
		end
		// apb writes to the tuning values land only while the sequencer is idle, so a pass sees stable values
		if (psel && penable && pwrite && s_q.st == SSL_IDLE) begin
			case (paddr)
				SSL_OFS_RAMP: s_d.ramp = pwdata[7:0];
				// gain is the knob for full scale and for mean grey matching
				SSL_OFS_GAIN: s_d.gain = pwdata[7:0];
				// offset is the knob for the dark clipping loop
				SSL_OFS_OFFSET: s_d.offset = pwdata[13:0];
				SSL_OFS_CTRL: begin
					if (pwdata[SSL_CTRL_LOAD_BIT] || (pwdata[SSL_CTRL_TUNE_BIT] && s_q.ver_ok)) begin
						// capture is withheld until the new pass is checked
						s_d.done = 1'b0;
						s_d.err = 1'b0;
						s_d.idx = 5'h00;
						s_d.verify = 1'b0;
						s_d.tune_only = !pwdata[SSL_CTRL_LOAD_BIT];
						s_d.st = pwdata[SSL_CTRL_LOAD_BIT] ? SSL_VER : SSL_RD;
					end
				end
				default: s_d.st = s_q.st;
			endcase
		end
		// sequencer
		case (s_q.st)
			SSL_IDLE: s_d.sreq.req = 1'b0;
			SSL_VER: begin
				s_d.sreq = '{req: 1'b1, we: 1'b0, addr: SSL_A_VERSION_CODE, wdata: 8'h00};
				if (s_q.sreq.req && sack.ack) begin
					s_d.sreq.req = 1'b0;
					s_d.ver = sack.rdata;
					s_d.ver_b = (sack.rdata == VER_B_CODE);
					s_d.ver_ok = (sack.rdata == VER_A_CODE) || (sack.rdata == VER_B_CODE);
					if (sack.rdata == VER_B_CODE) begin
						s_d.ramp = SSL_RAMP_INIT;
					end
					s_d.err = !((sack.rdata == VER_A_CODE) || (sack.rdata == VER_B_CODE));
					s_d.st = s_d.err ? SSL_IDLE : SSL_RD;
				end
			end
			SSL_RD: begin
				// read first: unlisted bits keep their value, and the check needs it too
				s_d.sreq = '{req: 1'b1, we: 1'b0, addr: cur.addr, wdata: 8'h00};
				if (s_q.sreq.req && sack.ack) begin
					s_d.sreq.req = 1'b0;
					s_d.rd = sack.rdata;
					s_d.st = s_q.verify ? SSL_CHK : SSL_WR;
				end
			end
			SSL_WR: begin
				s_d.sreq = '{req: 1'b1, we: 1'b1, addr: cur.addr,
					wdata: (s_q.rd & ~cur.mask) | (cur.val & cur.mask)};
				if (s_q.sreq.req && sack.ack) begin
					s_d.sreq.req = 1'b0;
					s_d.st = SSL_NEXT;
				end
			end
			SSL_CHK: begin
				// only the field bits are compared; other bits belong to the sensor
				if ((s_q.rd & cur.mask) != (cur.val & cur.mask)) begin
					s_d.err = 1'b1;
				end
				s_d.st = SSL_NEXT;
			end
			SSL_NEXT: begin
				if (s_q.idx == 5'((s_q.tune_only ? 5'h00 : fix_len) + SSL_TUNE_LEN - 5'h01)) begin
					s_d.idx = 5'h00;
					if (s_q.verify) begin
						s_d.done = !s_q.err;
						s_d.st = SSL_IDLE;
					end else begin
						s_d.verify = 1'b1;
						s_d.st = SSL_RD;
					end
				end else begin
					s_d.idx = 5'(s_q.idx + 5'h01);
					s_d.st = SSL_RD;
				end
			end
			default: s_d.st = SSL_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{st: SSL_IDLE, idx: 5'h00, verify: 1'b0, tune_only: 1'b0, ver_b: 1'b0, ver: 8'h00,
				ver_ok: 1'b0, done: 1'b0, err: 1'b0, rd: 8'h00, ramp: SSL_RAMP_INIT, gain: SSL_GAIN_INIT,
				offset: SSL_OFFSET_INIT, sreq: '{1'b0, 1'b0, 7'h00, 8'h00}, prdata: 32'h0000_0000,
				pslverr: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign sreq = s_q.sreq;
	assign prdata = s_q.prdata;
	assign pslverr = psel && penable && s_q.pslverr;
	assign pready = 1'b1;
	// capture only after a checked load, never mid-pass
	assign capture_enable = s_q.done && (s_q.st == SSL_IDLE);
endmodule : ssl_loader
`default_nettype wire

// ===== src/ssl_pkg.sv
// package for the sensor start-up register loader: offsets, fields, table entries, types
package ssl_pkg;
	// software register byte offsets
	localparam logic [7:0] SSL_OFS_CTRL = 8'h00;
	localparam logic [7:0] SSL_OFS_STATUS = 8'h04;
	localparam logic [7:0] SSL_OFS_RAMP = 8'h08;
	localparam logic [7:0] SSL_OFS_GAIN = 8'h0C;
	localparam logic [7:0] SSL_OFS_OFFSET = 8'h10;
	// control bits
	localparam int SSL_CTRL_LOAD_BIT = 0;
	localparam int SSL_CTRL_TUNE_BIT = 1;
	// status bits
	localparam int SSL_ST_BUSY_BIT = 0;
	localparam int SSL_ST_DONE_BIT = 1;
	localparam int SSL_ST_ERR_BIT = 2;
	localparam int SSL_ST_VERB_BIT = 3;
	localparam int SSL_ST_VERS_LSB = 8;
	// sensor register addresses
	localparam logic [6:0] SSL_A_EXPOSURE_MODE_SELECT = 7'h29;
	localparam logic [6:0] SSL_A_CALIBRATION_ENABLES = 7'h4D;
	localparam logic [6:0] SSL_A_OUTPUT_LANE_ENABLE = 7'h52;
	localparam logic [6:0] SSL_A_COLUMN_BIAS_CURRENT = 7'h54;
	localparam logic [6:0] SSL_A_COLUMN_PRECHARGE_CURRENT = 7'h55;
	localparam logic [6:0] SSL_A_CONVERTER_BIAS_CURRENT = 7'h56;
	localparam logic [6:0] SSL_A_AMPLIFIER_BIAS_CURRENT = 7'h57;
	localparam logic [6:0] SSL_A_TRANSFER_LOW_LEVEL = 7'h58;
	localparam logic [6:0] SSL_A_RESET_LOW_LEVEL = 7'h5B;
	localparam logic [6:0] SSL_A_PRECHARGE_LEVEL = 7'h5E;
	localparam logic [6:0] SSL_A_REFERENCE_LEVEL = 7'h5F;
	localparam logic [6:0] SSL_A_RAMP_START_FIRST = 7'h62;
	localparam logic [6:0] SSL_A_RAMP_START_SECOND = 7'h63;
	localparam logic [6:0] SSL_A_DARK_OFFSET_LOW = 7'h64;
	localparam logic [6:0] SSL_A_DARK_OFFSET_HIGH = 7'h65;
	localparam logic [6:0] SSL_A_PREAMP_GAIN_SELECT = 7'h66;
	localparam logic [6:0] SSL_A_CONVERTER_GAIN = 7'h67;
	localparam logic [6:0] SSL_A_CONFIG_ENABLE_SECOND = 7'h73;
	localparam logic [6:0] SSL_A_CONFIG_ENABLE_FIRST = 7'h75;
	localparam logic [6:0] SSL_A_SPARE_TUNING_BYTE = 7'h76;
	localparam logic [6:0] SSL_A_BLACK_SUN_CLAMP = 7'h7B;
	localparam logic [6:0] SSL_A_VERSION_CODE = 7'h7D;
	// field masks
	localparam logic [7:0] SSL_M3 = 8'h07;
	localparam logic [7:0] SSL_M2 = 8'h03;
	localparam logic [7:0] SSL_M4 = 8'h0F;
	localparam logic [7:0] SSL_M6 = 8'h3F;
	localparam logic [7:0] SSL_M7 = 8'h7F;
	localparam logic [7:0] SSL_M8 = 8'hFF;
	localparam logic [7:0] SSL_M1 = 8'h01;
	// table lengths
	localparam logic [4:0] SSL_V2_LEN = 5'h09;
	localparam logic [4:0] SSL_V3_LEN = 5'h0D;
	localparam logic [4:0] SSL_TUNE_LEN = 5'h05;
	// tuning limits and start values
	localparam logic [7:0] SSL_RAMP_MIN = 8'h66;
	localparam logic [7:0] SSL_RAMP_MAX = 8'h73;
	localparam logic [7:0] SSL_RAMP_INIT = 8'h6D;
	localparam logic [7:0] SSL_GAIN_V2_MIN = 8'h28;
	localparam logic [7:0] SSL_GAIN_V2_MAX = 8'h37;
	localparam logic [7:0] SSL_GAIN_V3_MAX = 8'h3F;
	localparam logic [7:0] SSL_GAIN_INIT = 8'h20;
	localparam logic [13:0] SSL_OFFSET_INIT = 14'h3FC3;

	// one table entry: address, field mask, field value
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] mask;
		logic [7:0] val;
	} ssl_entry_type;

	// sensor register access request
	typedef struct packed {
		logic req;
		logic we;
		logic [6:0] addr;
		logic [7:0] wdata;
	} ssl_sreq_type;

	// sensor register access answer
	typedef struct packed {
		logic ack;
		logic [7:0] rdata;
	} ssl_sack_type;

	// sequencer states
	typedef enum logic [5:0] {
		SSL_IDLE = 6'b000001,
		SSL_VER = 6'b000010,
		SSL_RD = 6'b000100,
		SSL_WR = 6'b001000,
		SSL_CHK = 6'b010000,
		SSL_NEXT = 6'b100000
	} ssl_state_type;
endpackage : ssl_pkg

// ===== verification/ssl_loader_assertions.sv
// concurrent checks on the loader's sensor request port
`timescale 1ns/1ps
`default_nettype none
module ssl_loader_assertions (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// apb side
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	// sensor side
	input wire ssl_pkg::ssl_sreq_type sreq,
	input wire ssl_pkg::ssl_sack_type sack,
	input wire logic capture_enable
);
	import ssl_pkg::*;
	logic pend_q; // load ordered, no request yet
	logic [6:0] rd_q; // last address read back
	logic [6:0] ramp_q; // last first-ramp field written
	// helper state: pend_q follows load orders and requests, the others completed transfers only
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pend_q <= 1'b0;
			rd_q <= '0;
			ramp_q <= '0;
		end else begin
			if (sreq.req) begin
				pend_q <= 1'b0;
			end else if (psel && penable && pwrite && paddr == SSL_OFS_CTRL && pwdata[SSL_CTRL_LOAD_BIT]) begin
				pend_q <= 1'b1;
			end
			if (sreq.req && sack.ack && !sreq.we) begin
				rd_q <= sreq.addr;
			end
			if (sreq.req && sack.ack && sreq.we && sreq.addr == SSL_A_RAMP_START_FIRST) begin
				ramp_q <= sreq.wdata[6:0];
			end
		end
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence s_wait; sreq.req && !sack.ack; endsequence
	sequence s_ack; sreq.req && sack.ack; endsequence
	sequence s_wr(a); sreq.req && sreq.we && sreq.addr == a; endsequence
	chk_req_hold: assert property (s_wait |=> sreq.req && $stable(sreq))
		else $error("request changed before ack");
	chk_req_drop: assert property (s_ack |=> !sreq.req)
		else $error("request held after ack");
	chk_ver_first: assert property (pend_q && sreq.req |-> !sreq.we && sreq.addr == SSL_A_VERSION_CODE)
		else $error("load did not start with version read");
	chk_ver_ro: assert property (sreq.req && sreq.we |-> sreq.addr != SSL_A_VERSION_CODE)
		else $error("write to version code");
	chk_cap_busy: assert property (sreq.req |-> !capture_enable)
		else $error("capture allowed during load");
	chk_ramp_same: assert property (s_wr(SSL_A_RAMP_START_SECOND) |-> sreq.wdata[6:0] == ramp_q)
		else $error("ramp registers differ");
	chk_ramp_range: assert property (s_wr(SSL_A_RAMP_START_FIRST) |-> sreq.wdata[6:0] inside {[7'h66:7'h73]})
		else $error("ramp out of range");
	chk_gain_max: assert property (s_wr(SSL_A_CONVERTER_GAIN) |-> sreq.wdata <= SSL_GAIN_V3_MAX)
		else $error("gain out of range");
	chk_rmw_order: assert property (sreq.req && sreq.we |-> sreq.addr == rd_q)
		else $error("write without prior read");
endmodule : ssl_loader_assertions
bind ssl_loader ssl_loader_assertions u_chk (.core_clk(core_clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .sreq(sreq), .sack(sack),
	.capture_enable(capture_enable));
`default_nettype wire

// ===== verification/ssl_sensor_model.sv
// behavioural sensor register bank answering byte requests
`timescale 1ns/1ps
`default_nettype none
module ssl_sensor_model (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// register port
	input wire ssl_pkg::ssl_sreq_type sreq,
	output var ssl_pkg::ssl_sack_type sack
);
	import ssl_pkg::*;
	logic [7:0] mem [128]; // register bank
	logic [7:0] ver = 8'hA2; // arbitrary version code
	int slow = 0; // wait cycles before ack
	logic [6:0] bad = 7'h00; // readback corrupted here if nonzero
	int cnt; // cycles the open request waited
	// non-default pattern, so untouched bits stay visible
	task automatic fill();
		for (int i = 0; i < 128; i++) begin
			mem[i] = {1'b1, 7'(i)} ^ 8'h5A;
		end
	endtask : fill
	// rdata toggles outside acks so a stale byte never matches
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sack <= '0;
			cnt <= 0;
		end else if (sreq.req && !sack.ack && cnt >= slow) begin
			sack.ack <= 1'b1;
			cnt <= 0;
			if (sreq.we && sreq.addr != SSL_A_VERSION_CODE) begin
				mem[sreq.addr] <= sreq.wdata;
			end
			sack.rdata <= (sreq.addr == SSL_A_VERSION_CODE) ? ver :
				mem[sreq.addr] ^ {7'h00, bad == sreq.addr && bad != 7'h00};
		end else begin
			sack.ack <= 1'b0;
			sack.rdata <= ~sack.rdata;
			cnt <= sreq.req ? cnt + 1 : 0;
		end
	end
endmodule : ssl_sensor_model
`default_nettype wire

// ===== verification/ssl_loader_tb_top.sv
// self-checking bench: apb master, sensor model, load and tune scenarios
`timescale 1ns/1ps
`default_nettype none
module ssl_loader_tb_top;
	import ssl_pkg::*;
	logic core_clk = 1'b0; // 20 MHz
	logic resetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ssl_sreq_type sreq;
	ssl_sack_type sack;
	logic capture_enable;
	logic [31:0] rd; // last read word
	logic err; // pslverr of last access
	int fail_count = 0;
	int samples_checked = 0;
	// expected fields: older silicon nine, newer thirteen
	localparam ssl_entry_type TAB[22] = '{'{7'h52, 8'h07, 8'h07}, '{7'h54, 8'h0F, 8'h04}, '{7'h55, 8'h0F, 8'h01},
		'{7'h58, 8'h7F, 8'h40}, '{7'h5B, 8'h7F, 8'h40}, '{7'h5E, 8'h7F, 8'h65}, '{7'h5F, 8'h7F, 8'h6A},
		'{7'h73, 8'h01, 8'h01}, '{7'h75, 8'h01, 8'h01}, '{7'h29, 8'h07, 8'h04}, '{7'h4D, 8'h03, 8'h00},
		'{7'h54, 8'h0F, 8'h04}, '{7'h55, 8'h0F, 8'h01}, '{7'h56, 8'h0F, 8'h0E}, '{7'h57, 8'h0F, 8'h0C},
		'{7'h58, 8'h7F, 8'h40}, '{7'h5B, 8'h7F, 8'h40}, '{7'h5E, 8'h7F, 8'h65}, '{7'h5F, 8'h7F, 8'h6A},
		'{7'h66, 8'h03, 8'h01}, '{7'h76, 8'hFF, 8'h01}, '{7'h7B, 8'h3F, 8'h62}};
	always #25 core_clk = ~core_clk;
	ssl_loader u_dut (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sreq(sreq),
		.sack(sack), .capture_enable(capture_enable));
	ssl_sensor_model u_sens (.core_clk(core_clk), .resetn(resetn), .sreq(sreq), .sack(sack));
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic guard(input bit hung);
		if (hung) begin
			fail_count++;
			finish_test();
		end
	endtask : guard
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			$display("[ERR] %0t got %h exp %h", $time, g, e);
			fail_count++;
		end
	endtask : check
	function automatic logic [7:0] ini(input logic [6:0] a);
		return {1'b1, a} ^ 8'h5A;
	endfunction : ini
	// one apb transfer, then an idle cycle so no signal is set twice at one edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		guard(n >= 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	// polls status until busy clears
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, SSL_OFS_STATUS, 32'h0);
			n++;
		end while (rd[SSL_ST_BUSY_BIT] !== 1'b0 && n < 1000);
		guard(n >= 1000);
	endtask : wait_idle
	task automatic t_regs();
		check(capture_enable, 1'b0);
		apb(1'b0, SSL_OFS_RAMP, 32'h0);
		check(rd, 32'h6D);
		apb(1'b0, SSL_OFS_GAIN, 32'h0);
		check(rd, 32'h20);
		apb(1'b0, SSL_OFS_OFFSET, 32'h0);
		check(rd, 32'h3FC3);
		check(err, 1'b0);
		apb(1'b0, 8'h14, 32'h0);
		check(err, 1'b1);
		$display("test regs done");
	endtask : t_regs
	task automatic t_load(input logic [7:0] v, input int s, input bit nw);
		logic [7:0] m;
		int lo;
		u_sens.fill();
		u_sens.ver = v;
		u_sens.slow = s;
		apb(1'b1, SSL_OFS_CTRL, 32'h1);
		wait_idle();
		check({rd[15:8], rd[3:0]}, {v, nw, 3'b010});
		lo = nw ? 9 : 0;
		for (int i = lo; i < lo + (nw ? 13 : 9); i++) begin
			m = TAB[i].mask;
			check(u_sens.mem[TAB[i].addr], (ini(TAB[i].addr) & ~m) | (TAB[i].val & m));
		end
		check(u_sens.mem[7'h28], ini(7'h28));
		check(u_sens.mem[7'h62][6:0], 7'h6D);
		check(u_sens.mem[7'h63][6:0], 7'h6D);
		check(u_sens.mem[7'h67], nw ? 8'h20 : 8'h28);
		check({u_sens.mem[7'h65][5:0], u_sens.mem[7'h64]}, 14'h3FC3);
		check(capture_enable, 1'b1);
		$display("test load done");
	endtask : t_load
	// out-of-range tuning, plus a write refused while busy
	task automatic t_tune();
		apb(1'b1, SSL_OFS_RAMP, 32'h65);
		apb(1'b1, SSL_OFS_GAIN, 32'h50);
		apb(1'b1, SSL_OFS_OFFSET, 32'h0);
		apb(1'b1, SSL_OFS_CTRL, 32'h2);
		apb(1'b1, SSL_OFS_RAMP, 32'h70);
		wait_idle();
		check(rd[2:0], 3'b010);
		apb(1'b0, SSL_OFS_RAMP, 32'h0);
		check(rd, 32'h65);
		check(u_sens.mem[7'h62][6:0], 7'h66);
		check(u_sens.mem[7'h63][6:0], 7'h66);
		check(u_sens.mem[7'h67], 8'h3F);
		check(u_sens.mem[7'h64], 8'h00);
		check(u_sens.mem[7'h65], ini(7'h65) & 8'hC0);
		check(capture_enable, 1'b1);
		$display("test tune done");
	endtask : t_tune
	// readback mismatch, then an unrecognised version
	task automatic t_fault();
		u_sens.bad = SSL_A_COLUMN_BIAS_CURRENT;
		apb(1'b1, SSL_OFS_CTRL, 32'h1);
		wait_idle();
		check({rd[2], capture_enable}, 2'b10);
		u_sens.bad = 7'h00;
		u_sens.ver = 8'h11;
		apb(1'b1, SSL_OFS_CTRL, 32'h1);
		wait_idle();
		check({rd[2], capture_enable}, 2'b10);
		// a tune order without a known version must be dropped
		apb(1'b1, SSL_OFS_CTRL, 32'h2);
		apb(1'b0, SSL_OFS_STATUS, 32'h0);
		check(rd[2:0], 3'b100);
		$display("test fault done");
	endtask : t_fault
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_regs();
		t_load(8'hA2, 0, 1'b0);
		t_load(8'hB3, 3, 1'b1);
		t_tune();
		t_fault();
		finish_test();
	end
endmodule : ssl_loader_tb_top
`default_nettype wire
